// ### hdl/sbsc_burst_counter.sv
/*
  Two-bit burst address counter: preset from the low address bits on a
  load, stepped on advance, linear or interleaved order.
  Assumes load and advance are never both high; the caller enforces it.
  low_next is the low address bits that apply after the coming edge.
*/
`timescale 1ns/1ps

module sbsc_burst_counter (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          reset,
  // control
  input  wire logic                          load,
  input  wire logic                          advance,
  input  wire logic                          order_interleaved,
  input  wire logic [sbsc_pkg::LOW_W-1:0]    preset,
  // result
  output logic      [sbsc_pkg::LOW_W-1:0]    low_next
);

  logic [sbsc_pkg::LOW_W-1:0] start_q;
  logic [sbsc_pkg::LOW_W-1:0] start_d;
  logic [sbsc_pkg::LOW_W-1:0] step_q;
  logic [sbsc_pkg::LOW_W-1:0] step_d;

  // step count wraps after four addresses, so the fifth returns to the start
  always_comb begin
    start_d = start_q;
    step_d  = step_q;
    if (load) begin
      start_d = preset;                                          // [R3]
      step_d  = sbsc_pkg::STEP_FIRST;
    end else if (advance) begin
      step_d = step_q + sbsc_pkg::STEP_ONE;                      // [R5] [R20]
    end
  end

  // order applied to start and step
  always_comb begin
    if (order_interleaved) begin
      low_next = start_d ^ step_d;                               // [R6] [R19]
    end else begin
      low_next = start_d + step_d;                               // [R19]
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      start_q <= sbsc_pkg::STEP_FIRST;
      step_q  <= sbsc_pkg::STEP_FIRST;
    end else begin
      start_q <= start_d;
      step_q  <= step_d;
    end
  end

endmodule

// ### hdl/sbsc_pkg.sv
/*
  Shared constants, cycle type and write-lane decode for the synchronous
  burst SRAM control block.
  Assumes a single clock domain; every user of these names refers to them
  as sbsc_pkg::name.
*/
package sbsc_pkg;

  // array organisation: 256K words of 36 bits, four 9-bit byte lanes
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned LOW_W  = 2;
  localparam int unsigned HIGH_W = ADDR_W - LOW_W;
  localparam int unsigned DATA_W = 36;
  localparam int unsigned LANES  = 4;
  localparam int unsigned LANE_W = DATA_W / LANES;
  localparam int unsigned DEPTH  = 262144;

  // mode input levels
  localparam logic ORDER_LINEAR      = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;
  localparam logic DESEL_DUAL        = 1'b0;
  localparam logic DESEL_SINGLE      = 1'b1;

  // burst step counter values
  localparam logic [LOW_W-1:0] STEP_FIRST = 2'h0;
  localparam logic [LOW_W-1:0] STEP_ONE   = 2'h1;

  // reset values of the datapath registers
  localparam logic [HIGH_W-1:0] HIGH_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h000000000;

  // lane masks
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [LANES-1:0] LANES_ALL  = 4'hF;

  typedef logic [LANES-1:0] sbsc_lanes_t;

  // registered cycle type, one-hot
  typedef enum logic [3:0] {
    CYC_IDLE  = 4'h1,
    CYC_READ  = 4'h2,
    CYC_WRITE = 4'h4,
    CYC_DESEL = 4'h8
  } sbsc_cycle_t;

  // lanes stored by a cycle; all-lane write overrides the byte controls
  function automatic sbsc_lanes_t sbsc_lane_mask(input logic        all_lane_n,
                                                 input logic        byte_en_n,
                                                 input sbsc_lanes_t lane_sel_n);
    sbsc_lanes_t mask;
    mask = LANES_NONE;
    if (!all_lane_n) begin
      mask = LANES_ALL;
    end else if (!byte_en_n) begin
      mask = ~lane_sel_n;
    end
    return mask;
  endfunction

endpackage

// ### hdl/sbsc_top.sv
/*
  Synchronous burst SRAM core: input registers, burst counter, 256K x 36
  array with byte-lane writes, pipelined output register, single or dual
  cycle deselect, asynchronous output enable and sleep.
  Assumes the controller drives every synchronous input set up to the rising
  clock edge, presents write data in the same cycle as its address, and lets
  the pads pull unconnected mode inputs to their default levels.
*/
// Contract
// R1 - controls, address and data are taken only on the rising clock edge
// R2 - output enable and sleep request act without waiting for a clock
// R3 - a two-bit counter supplies low address bits, preset on each load
// R4 - either address strobe starts a burst and loads the presented address
// R5 - later burst addresses step internally only while advance is asserted
// R6 - burst order select picks linear or interleaved counting
// R7 - a fresh address may be loaded every cycle without lost cycles
// R8 - dual-cycle deselect travels the same pipeline depth as a read
// R9 - single-cycle deselect releases outputs as soon as it is registered
// R10 - dual-cycle deselect holds a full cycle, releasing after the next edge
// R11 - the deselect mode input level chooses single or dual cycle deselect
// R12 - unconnected mode inputs give single deselect, interleaved order, pipelined output
// R13 - byte write stores only lanes selected while byte write enable is asserted
// R14 - all-lane write stores every lane whatever the byte controls say
// R15 - a registered write is timed internally, no external write pulse
// R16 - sleep is entered on sleep request high or with the clock stopped; the code enters it on sleep request high only
// R17 - array contents are kept unchanged during sleep
// R18 - array is 256K words of 36 bits, high address plus counter bits
// R19 - burst order low is linear, high is interleaved as start xor step
// R20 - a burst yields four addresses then wraps to the first on the fifth
// R21 - selected only with both low-active selects low and the high select high
// R22 - a selected cycle writes on all-lane write or byte write with a lane
// R23 - read data leaves an output register the edge after the array access
`timescale 1ns/1ps

module sbsc_top (
  // clock and reset
  input  wire logic                                clock,
  input  wire logic                                reset,
  // address
  input  wire logic [sbsc_pkg::HIGH_W-1:0]         address_high,
  input  wire logic [sbsc_pkg::LOW_W-1:0]          low_address_preset,
  // chip selects
  input  wire logic                                chip_select_primary_n,
  input  wire logic                                chip_select_positive,
  input  wire logic                                chip_select_secondary_n,
  // address strobes and burst advance
  input  wire logic                                processor_address_strobe_n,
  input  wire logic                                controller_address_strobe_n,
  input  wire logic                                burst_advance_n,
  // write controls
  input  wire logic                                byte_write_enable_n,
  input  wire logic [sbsc_pkg::LANES-1:0]          lane_write_select_n,
  input  wire logic                                all_lane_write_n,
  // asynchronous controls
  input  wire logic                                output_enable_n,
  input  wire logic                                sleep_request,
  // mode inputs
  input  wire logic                                burst_order_select,
  input  wire logic                                deselect_mode_select,
  // data bus, split into its three signals
  input  wire logic [sbsc_pkg::DATA_W-1:0]         data_in,
  output logic      [sbsc_pkg::DATA_W-1:0]         data_out,
  output logic                                     data_oe,
  // status
  output logic                                     sleep_active
);

  // array storage, never reset so contents survive reset and sleep [R18]
  logic [sbsc_pkg::DATA_W-1:0] mem [0:sbsc_pkg::DEPTH-1];

  // input stage registers
  sbsc_pkg::sbsc_cycle_t        cycle_q;
  sbsc_pkg::sbsc_cycle_t        cycle_d;
  logic                         selected_q;
  logic                         selected_d;
  logic [sbsc_pkg::HIGH_W-1:0]  high_q;
  logic [sbsc_pkg::HIGH_W-1:0]  high_d;
  logic [sbsc_pkg::ADDR_W-1:0]  addr_q;
  logic [sbsc_pkg::LOW_W-1:0]   low_next;
  sbsc_pkg::sbsc_lanes_t        lanes_q;
  logic [sbsc_pkg::DATA_W-1:0]  wdata_q;

  // output stage registers
  logic [sbsc_pkg::DATA_W-1:0]  data_out_q;
  logic                         drive_q;
  logic                         drive_d;
  logic                         sleep_q;

  // decoded inputs of the current cycle
  logic                         strobe;
  logic                         chip_selected;
  logic                         load;
  logic                         advance;
  logic                         order_interleaved;
  logic                         single_deselect;
  sbsc_pkg::sbsc_lanes_t        lanes_now;
  logic                         write_now;

  // mode decode: high or pulled-up levels give the default modes [R12]
  assign order_interleaved = (burst_order_select == sbsc_pkg::ORDER_INTERLEAVED);   // [R6] [R19]
  assign single_deselect   = (deselect_mode_select == sbsc_pkg::DESEL_SINGLE);      // [R11] [R12]

  // either strobe starts a new access; sleep masks all synchronous inputs
  assign strobe        = !processor_address_strobe_n || !controller_address_strobe_n; // [R4]
  assign load          = strobe && !sleep_request;                                    // [R4] [R7]
  assign chip_selected = !chip_select_primary_n && chip_select_positive
                         && !chip_select_secondary_n;                                 // [R21]

  // advance only steps a burst that is already in progress and selected
  assign advance = !strobe && !burst_advance_n && selected_q && !sleep_request;        // [R5]

  // write decode shared by new and continuing cycles
  assign lanes_now = sbsc_pkg::sbsc_lane_mask(all_lane_write_n,
                                              byte_write_enable_n,
                                              lane_write_select_n);                   // [R13] [R14]
  assign write_now = (lanes_now != sbsc_pkg::LANES_NONE);                             // [R22]

  // burst counter supplies the low address bits
  sbsc_burst_counter u_counter (
    .clock             (clock),
    .reset             (reset),
    .load              (load),
    .advance           (advance),
    .order_interleaved (order_interleaved),
    .preset            (low_address_preset),
    .low_next          (low_next)
  );

  // high address is taken on a load and held through the burst
  assign high_d = load ? address_high : high_q;                                       // [R4]

  // cycle classification; a continuing cycle keeps the selection of its burst
  always_comb begin
    cycle_d    = sbsc_pkg::CYC_DESEL;
    selected_d = selected_q;
    if (sleep_request) begin
      cycle_d    = sbsc_pkg::CYC_IDLE;                                                // [R16]
      selected_d = 1'b0;
    end else if (strobe) begin
      selected_d = chip_selected;                                                     // [R21]
      if (!chip_selected) begin
        cycle_d = sbsc_pkg::CYC_DESEL;
      end else if (write_now) begin
        cycle_d = sbsc_pkg::CYC_WRITE;                                                // [R22]
      end else begin
        cycle_d = sbsc_pkg::CYC_READ;                                                 // [R22]
      end
    end else if (selected_q) begin
      if (write_now) begin
        cycle_d = sbsc_pkg::CYC_WRITE;                                                // [R22]
      end else begin
        cycle_d = sbsc_pkg::CYC_READ;
      end
    end
  end

  // input registers: everything synchronous is captured on the rising edge only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cycle_q    <= sbsc_pkg::CYC_IDLE;
      selected_q <= 1'b0;
    end else begin
      cycle_q    <= cycle_d;                                                          // [R1]
      selected_q <= selected_d;
    end
  end

  // address register combines held high bits with the counter bits
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      high_q <= sbsc_pkg::HIGH_RESET;
      addr_q <= sbsc_pkg::ADDR_RESET;
    end else begin
      high_q <= high_d;                                                               // [R1]
      addr_q <= {high_d, low_next};                                                   // [R3] [R18] [R7]
    end
  end

  // write data and lanes are registered with the address of the same cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lanes_q <= sbsc_pkg::LANES_NONE;
      wdata_q <= sbsc_pkg::DATA_RESET;
    end else begin
      lanes_q <= lanes_now;                                                           // [R1] [R13]
      wdata_q <= data_in;                                                             // [R1]
    end
  end

  // self-timed array write one edge after capture; only the chosen lanes change.
  // sleep yields idle cycles, so nothing new reaches the array while asleep
  always_ff @(posedge clock) begin
    if (cycle_q == sbsc_pkg::CYC_WRITE) begin                                         // [R15] [R17]
      for (int lane = 0; lane < sbsc_pkg::LANES; lane++) begin
        if (lanes_q[lane]) begin
          mem[addr_q][lane*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W] <=
            wdata_q[lane*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W];                       // [R13] [R14]
        end
      end
    end
  end

  // pipelined read: the output register loads the word one edge after capture;
  // a write captured the cycle before has already landed, so no bypass is needed
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      data_out_q <= sbsc_pkg::DATA_RESET;
    end else if (cycle_q == sbsc_pkg::CYC_READ) begin
      data_out_q <= mem[addr_q];                                                      // [R23]
    end
  end

  // drive decision for the interval after this edge:
  // single deselect cuts the drive as the deselect is captured, dual deselect
  // follows the read pipeline and cuts one edge later
  always_comb begin
    drive_d = 1'b0;
    if (single_deselect && (cycle_d == sbsc_pkg::CYC_DESEL)) begin
      drive_d = 1'b0;                                                                 // [R9]
    end else if (cycle_d == sbsc_pkg::CYC_WRITE) begin
      drive_d = 1'b0;                          // turn the bus round for write data
    end else begin
      unique case (cycle_q)
        sbsc_pkg::CYC_READ:  drive_d = 1'b1;                                          // [R23]
        sbsc_pkg::CYC_DESEL: drive_d = 1'b0;                                          // [R8] [R10]
        sbsc_pkg::CYC_WRITE: drive_d = 1'b0;
        sbsc_pkg::CYC_IDLE:  drive_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= drive_d;                                                             // [R8] [R9] [R11]
    end
  end

  // sleep status flag for the system; the clocked copy lags the request
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_request;                                                       // [R16]
    end
  end

  // output enable and sleep gate the drive with no clock involved; this is the
  // one output that is not a bare flop, since waiting for an edge would break
  // the asynchronous turn-off the bus expects
  assign data_oe      = drive_q && !output_enable_n && !sleep_request;                // [R2] [R16]
  assign data_out     = data_out_q;
  assign sleep_active = sleep_q;

endmodule

// ### verif/sbsc_ctrl_model.sv
/*
  Controller model driving the synchronous side of the SRAM core.
  Assumes the same clock as the core; changes inputs 1 ns after an edge.
*/
`timescale 1ns/1ps

module sbsc_ctrl_model (
  // clock
  input wire logic    clock,
  // address, selects, strobes
  output logic [15:0] address_high,
  output logic [1:0]  low_address_preset,
  output logic        chip_select_primary_n,
  output logic        chip_select_positive,
  output logic        chip_select_secondary_n,
  output logic        processor_address_strobe_n,
  output logic        controller_address_strobe_n,
  output logic        burst_advance_n,
  // write controls and data
  output logic        byte_write_enable_n,
  output logic [3:0]  lane_write_select_n,
  output logic        all_lane_write_n,
  output logic [35:0] data_in
);
  // idle bus at time zero: strobes off, core not selected
  initial {address_high, low_address_preset, chip_select_primary_n, chip_select_positive,
           chip_select_secondary_n, processor_address_strobe_n, controller_address_strobe_n,
           burst_advance_n, byte_write_enable_n, lane_write_select_n, all_lane_write_n, data_in} = '1;

  // one bus cycle, held until the next call
  task automatic cyc(input logic [5:0] k, input logic [17:0] a, input logic [5:0] w, input logic [35:0] d);
    @(posedge clock);
    #1;
    {address_high, low_address_preset} = a;
    processor_address_strobe_n = !k[0];
    controller_address_strobe_n = !k[1];
    chip_select_primary_n = !k[2];
    chip_select_positive = k[3];
    chip_select_secondary_n = !k[4];
    burst_advance_n = !k[5];
    {all_lane_write_n, byte_write_enable_n, lane_write_select_n} = w;
    // data lines keep toggling when neither write control is low, so a stale word never passes
    data_in = (w[5] && w[4]) ? ~data_in : d;
  endtask
endmodule

// ### verif/sbsc_top_properties.sv
/*
  Port-level timing checks for the burst SRAM core.
  Assumes it is bound onto sbsc_top and shares its single clock.
*/
`timescale 1ns/1ps

module sbsc_top_chk (
  // clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // synchronous inputs
  input wire logic [15:0] address_high,
  input wire logic [1:0]  low_address_preset,
  input wire logic        chip_select_primary_n,
  input wire logic        chip_select_positive,
  input wire logic        chip_select_secondary_n,
  input wire logic        processor_address_strobe_n,
  input wire logic        controller_address_strobe_n,
  input wire logic        burst_advance_n,
  input wire logic        byte_write_enable_n,
  input wire logic [3:0]  lane_write_select_n,
  input wire logic        all_lane_write_n,
  // asynchronous and mode inputs
  input wire logic        output_enable_n,
  input wire logic        sleep_request,
  input wire logic        burst_order_select,
  input wire logic        deselect_mode_select,
  // data and status
  input wire logic [35:0] data_in,
  input wire logic [35:0] data_out,
  input wire logic        data_oe,
  input wire logic        sleep_active
);
  // cycle kinds as the core registers them; no-strobe cycles left out on purpose
  wire stb = !processor_address_strobe_n || !controller_address_strobe_n;
  wire hit = !chip_select_primary_n && chip_select_positive && !chip_select_secondary_n;
  wire wr  = !all_lane_write_n || (!byte_write_enable_n && lane_write_select_n != 4'hF);
  wire rd  = stb && hit && !wr && !sleep_request;
  wire ds  = stb && !hit && !sleep_request;
  wire en  = !output_enable_n && !sleep_request;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  oe_gate_a: assert property (output_enable_n |-> !data_oe) else $error("drive with output enable off");
  sleep_gate_a: assert property (sleep_request |-> !data_oe) else $error("drive during sleep");
  sleep_flag_a: assert property (!$past(reset) |-> sleep_active == $past(sleep_request))
    else $error("sleep status does not follow request");
  write_turn_a: assert property (stb && hit && wr && !sleep_request |=> !data_oe)
    else $error("drive after captured write");
  read_drive_a: assert property (rd ##1 rd |=> data_oe == en) else $error("read not driven");
  single_rel_a: assert property (rd ##1 (ds && deselect_mode_select) |=> !data_oe)
    else $error("single deselect kept driving");
  dual_hold_a: assert property (rd ##1 (ds && !deselect_mode_select) |=> data_oe == en)
    else $error("dual deselect released early");
  dual_rel_a: assert property (ds ##1 (ds && !deselect_mode_select) |=> !data_oe)
    else $error("dual deselect never released");
  data_hold_a: assert property ((ds || sleep_request) |-> ##2 $stable(data_out))
    else $error("read data changed without a read");

  desel_c: cover property (rd ##1 ds ##1 ds);
  sleep_c: cover property (sleep_active);
  write_c: cover property (stb && hit && wr);
endmodule

bind sbsc_top sbsc_top_chk i_chk (.clock, .reset, .address_high, .low_address_preset, .chip_select_primary_n,
  .chip_select_positive, .chip_select_secondary_n, .processor_address_strobe_n, .controller_address_strobe_n,
  .burst_advance_n, .byte_write_enable_n, .lane_write_select_n, .all_lane_write_n, .output_enable_n,
  .sleep_request, .burst_order_select, .deselect_mode_select, .data_in, .data_out, .data_oe, .sleep_active);

// ### verif/sync_burst_sram_control_test.sv
/*
  Self-checking bench for sbsc_top: the controller model drives the bus,
  the bench drives the asynchronous and mode pins and judges the outputs.
*/
`timescale 1ns/1ps

module sync_burst_sram_control_test;
  logic [15:0] address_high;
  logic [1:0]  low_address_preset;
  logic [3:0]  lane_write_select_n;
  logic [35:0] data_in, data_out;
  logic        chip_select_primary_n, chip_select_positive, chip_select_secondary_n;
  logic        processor_address_strobe_n, controller_address_strobe_n, burst_advance_n;
  logic        byte_write_enable_n, all_lane_write_n, data_oe, sleep_active;
  logic        clock = 1'h0, reset = 1'h1, output_enable_n = 1'h0, sleep_request = 1'h0;
  logic        burst_order_select = 1'h1, deselect_mode_select = 1'h1; // pads pull up when open
  int          err_count = 0, check_count = 0, cycles = 0;
  // k = {step, sec, pos, pri, cs strobe, ps strobe}; w = {all_n, byte_n, lanes_n}
  localparam logic [5:0]  RD = 6'h1D, RC = 6'h1E, DS = 6'h01, ST = 6'h20, HO = 6'h00;
  localparam logic [5:0]  NW = 6'h3F, WA = 6'h0F, WB = 6'h2A, WN = 6'h2F;
  localparam logic [35:0] D1 = 36'h123456789, D2 = 36'hABCDEF012, M02 = 36'h007FC01FF;
  localparam logic [35:0] MRG = (D2 & M02) | (D1 & ~M02);
  localparam logic [17:0] ADR = 18'h00100;

  sbsc_ctrl_model i_ctrl (.clock, .address_high, .low_address_preset, .chip_select_primary_n,
    .chip_select_positive, .chip_select_secondary_n, .processor_address_strobe_n,
    .controller_address_strobe_n, .burst_advance_n, .byte_write_enable_n, .lane_write_select_n,
    .all_lane_write_n, .data_in);
  sbsc_top i_dut (.clock, .reset, .address_high, .low_address_preset, .chip_select_primary_n,
    .chip_select_positive, .chip_select_secondary_n, .processor_address_strobe_n,
    .controller_address_strobe_n, .burst_advance_n, .byte_write_enable_n, .lane_write_select_n,
    .all_lane_write_n, .output_enable_n, .sleep_request, .burst_order_select,
    .deselect_mode_select, .data_in, .data_out, .data_oe, .sleep_active);

  initial forever #2.5 clock = ~clock;

  // hang guard: the whole run needs about 75 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read one word back; data is settled two cycles after the read
  task automatic rd_back(input logic [35:0] exp);
    i_ctrl.cyc(RD, ADR, NW, 36'h0);
    i_ctrl.cyc(DS, ADR, NW, 36'h0);
    i_ctrl.cyc(DS, ADR, NW, 36'h0);
    chk(data_out, exp);
  endtask

  task automatic t_write();
    i_ctrl.cyc(RD, ADR, WA, D1); // all-lane write with byte enable but no lane
    i_ctrl.cyc(RC, ADR, WB, D2); // lanes 0 and 2 only, back to back
    i_ctrl.cyc(RD, ADR, WN, 36'hFFFFFFFFF); // byte enable without lanes reads
    i_ctrl.cyc(DS, ADR, NW, 36'h0);
    i_ctrl.cyc(DS, ADR, NW, 36'h0);
    chk(data_out, MRG);
    $display("t_write done");
  endtask

  task automatic t_burst();
    logic [35:0] e [8];
    logic [1:0]  s;
    int          st;
    for (int o = 0; o < 2; o++) begin
      burst_order_select = o[0];
      for (int i = 0; i < 4; i++) i_ctrl.cyc(RD, {16'h0200, i[1:0]}, WA, 36'h5A5A5A5A0 | i);
      st = 0;
      // cycle 2 holds without a step, so four steps land on cycle 5 and wrap
      for (int c = 0; c < 8; c++) begin
        if (c > 0 && c < 6 && c != 2) st++;
        s = o[0] ? (2'h1 ^ st[1:0]) : (2'h1 + st[1:0]);
        e[c] = 36'h5A5A5A5A0 | s;
        i_ctrl.cyc(c == 0 ? (o[0] ? RC : RD) : c < 6 ? (c == 2 ? HO : ST) : DS, 18'h00801, NW, 36'h0);
        if (c > 1) chk(data_out, e[c-2]);
      end
    end
    $display("t_burst done");
  endtask

  task automatic t_desel();
    for (int m = 0; m < 2; m++) begin
      deselect_mode_select = m[0];
      // two reads so the second edge already drives, whatever the deselect mode
      i_ctrl.cyc(RD, ADR, NW, 36'h0);
      i_ctrl.cyc(RD, ADR, NW, 36'h0);
      i_ctrl.cyc(DS, ADR, NW, 36'h0);
      chk(36'(data_oe), 36'h1);
      output_enable_n = 1'h1;
      #1 chk(36'(data_oe), 36'h0);
      output_enable_n = 1'h0;
      i_ctrl.cyc(DS, ADR, NW, 36'h0);
      chk(36'(data_oe), m ? 36'h0 : 36'h1);
      i_ctrl.cyc(DS, ADR, NW, 36'h0);
      chk(36'(data_oe), 36'h0);
      chk(data_out, MRG);
    end
    $display("t_desel done");
  endtask

  task automatic t_sleep();
    i_ctrl.cyc(RD, ADR, NW, 36'h0);
    i_ctrl.cyc(RD, ADR, NW, 36'h0);
    i_ctrl.cyc(RD, ADR, NW, 36'h0);
    chk(36'(data_oe), 36'h1);
    sleep_request = 1'h1;
    #1 chk(36'(data_oe), 36'h0);
    i_ctrl.cyc(RD, ADR, WA, 36'h0); // write attempt while asleep
    chk(36'(sleep_active), 36'h1);
    // the write attempt is captured at the next edge, so sleep stays up past it
    i_ctrl.cyc(DS, ADR, NW, 36'h0);
    sleep_request = 1'h0;
    rd_back(MRG);
    $display("t_sleep done");
  endtask

  task automatic t_select();
    // each select alone off: the write must be dropped
    for (int i = 0; i < 3; i++) i_ctrl.cyc(RD & ~(6'h04 << i), ADR, WA, 36'h0);
    rd_back(MRG);
    $display("t_select done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clock);
    #1 reset = 1'h0;
    t_write();
    t_burst();
    t_desel();
    t_sleep();
    t_select();
    give_verdict();
  end
endmodule
